// ### core/rtc_pkg.sv
package rtc_pkg;
    // timing
    localparam int CLK_KHZ      = 20000;
    localparam int TICK_MS      = 100;
    localparam int TICK_CYC_DOC = TICK_MS * CLK_KHZ;

    // select codes on the host port
    localparam logic [3:0] SEL_STATUS = 4'h0;
    localparam logic [3:0] SEL_TENTHS = 4'h1;
    localparam logic [3:0] SEL_SEC    = 4'h2;
    localparam logic [3:0] SEL_MIN    = 4'h3;
    localparam logic [3:0] SEL_HOUR   = 4'h4;
    localparam logic [3:0] SEL_DAY    = 4'h5;
    localparam logic [3:0] SEL_MONTH  = 4'h6;
    localparam logic [3:0] SEL_YEAR   = 4'h7;
    localparam logic [3:0] SEL_LEAP   = 4'h8;
    localparam logic [3:0] SEL_TCTRL  = 4'h9;
    localparam logic [3:0] SEL_TRUN   = 4'hA;

    // counter chain indices
    localparam int N_CNT  = 8;
    localparam int C_TEN  = 0;
    localparam int C_DAY  = 4;
    localparam int C_MON  = 5;
    localparam int C_YEAR = 6;
    localparam int C_LEAP = 7;

    // status bit positions
    localparam int ST_UPDATE = 0;
    localparam int ST_TIMER  = 1;

    // timer control: [2:0] period code, [3] repeat
    localparam int TC_REPEAT = 3;
    localparam logic [3:0] TCTRL_RESET = 4'h0;
    localparam logic [7:0] CNT_RESET   = 8'h00;
    localparam logic [7:0] ONE_RESET   = 8'h01;

    localparam logic [1:0] LEAP_MAX = 2'h3;

    // period in 100 ms ticks for each code; code 0 is disabled
    function automatic logic [9:0] period_ticks(input logic [2:0] code);
        case (code)
            3'h1:    period_ticks = 10'h001;
            3'h2:    period_ticks = 10'h005;
            3'h3:    period_ticks = 10'h00A;
            3'h4:    period_ticks = 10'h032;
            3'h5:    period_ticks = 10'h064;
            3'h6:    period_ticks = 10'h12C;
            3'h7:    period_ticks = 10'h258;
            default: period_ticks = 10'h000;
        endcase
    endfunction : period_ticks

    function automatic logic [7:0] days_in(input logic [7:0] mon,
                                           input logic       leap);
        case (mon)
            8'h02:   days_in = leap ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: days_in = 8'h1E;
            default: days_in = 8'h1F;
        endcase
    endfunction : days_in
endpackage : rtc_pkg

// ### core/rtc_interval_timer.sv
`timescale 1ns/100ps
module rtc_interval_timer
    import rtc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       ctrl_wr,
    input  wire logic [3:0] ctrl_data,
    input  wire logic       run_wr,
    input  wire logic       run_data,
    output logic      [3:0] ctrl,
    output logic            running,
    output logic            timeout
);
    logic [9:0] count;
    logic [3:0] next_ctrl;
    logic       next_running;
    logic [9:0] next_count;
    logic       next_timeout;
    logic [9:0] period;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        period       = period_ticks(ctrl[2:0]);
        next_ctrl    = ctrl_wr ? ctrl_data : ctrl;
        next_running = running;
        next_count   = count;
        next_timeout = 1'b0;
        if (ctrl_wr && ctrl_data == TCTRL_RESET) begin
            next_running = 1'b0;
        end else if (run_wr) begin
            next_running = run_data;
            next_count   = 10'h000;
        end else if (running && tick && period != 10'h000) begin
            if (count + 10'h001 == period) begin
                next_timeout = 1'b1;
                next_count   = 10'h000;
                next_running = ctrl[TC_REPEAT];
            end else begin
                next_count = count + 10'h001;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl    <= TCTRL_RESET;
            running <= 1'b0;
            count   <= 10'h000;
            timeout <= 1'b0;
        end else begin
            ctrl    <= next_ctrl;
            running <= next_running;
            count   <= next_count;
            timeout <= next_timeout;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_disabled_quiet;
        @(posedge clk) disable iff (rst)
        ctrl == TCTRL_RESET |-> !timeout;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("timer timed out while disabled");

    property p_restart;
        @(posedge clk) disable iff (rst)
        run_wr && run_data |=> !timeout && count == 10'h000;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart did not clear the period");

    property p_single_shot;
        @(posedge clk) disable iff (rst)
        timeout && !ctrl[TC_REPEAT] && !run_wr && !ctrl_wr |-> !running;
    endproperty
    a_single_shot: assert property (p_single_shot)
        else $error("single shot timer kept running");

    c_repeat: cover property (@(posedge clk) disable iff (rst)
        timeout && running);
endmodule : rtc_interval_timer

// ### core/rtc_core.sv
`timescale 1ns/100ps
module rtc_core
    import rtc_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYC_DOC
)
(
    input  wire logic       SYS_CLK,
    input  wire logic       RESET,
    input  wire logic       WR_STB,
    input  wire logic [3:0] WR_SEL,
    input  wire logic [7:0] WR_DATA,
    input  wire logic       RD_STB,
    input  wire logic [3:0] RD_SEL,
    input  wire logic       HALT_COUNT,
    output logic      [7:0] READ_DATA,
    output logic            UPDATE_SEEN_FLAG,
    output logic            TIMER_FLAG,
    output logic            INT_N_OUT,
    output logic            INT_N_OE
);
    localparam int PIN_W = 19;

    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic             wr_d;
    logic             rd_d;
    logic             halt_s;
    logic             wr_s;
    logic             rd_s;
    logic [3:0]       wsel;
    logic [7:0]       wdata;
    logic [3:0]       rsel;
    logic             wr_pulse;
    logic             rd_pulse;

    ////////////////////////////////////////////////////////////////////////
    // all pins but SYS_CLK and RESET pass two flops; data is held stable across its strobe
    assign {halt_s, wr_s, rd_s, wsel, wdata, rsel} = pin_s2;
    assign wr_pulse = wr_s & ~wr_d;
    assign rd_pulse = rd_s & ~rd_d;

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            wr_d   <= 1'b0;
            rd_d   <= 1'b0;
        end else begin
            pin_s1 <= {HALT_COUNT, WR_STB, RD_STB, WR_SEL, WR_DATA, RD_SEL};
            pin_s2 <= pin_s1;
            wr_d   <= wr_s;
            rd_d   <= rd_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // prescaler; held at zero in halt so restart lines up with release
    logic [31:0] pre;
    logic [31:0] next_pre;
    logic        tick;
    logic        next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_pre  = pre + 32'h0000_0001;
        if (halt_s) begin
            next_pre = 32'h0000_0000;
        end else if (pre == 32'(TICK_CYCLES - 1)) begin
            next_pre  = 32'h0000_0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            pre  <= 32'h0000_0000;
            tick <= 1'b0;
        end else begin
            pre  <= next_pre;
            tick <= next_tick;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counter chain
    logic [7:0] cnt      [N_CNT];
    logic [7:0] next_cnt [N_CNT];
    logic       carry;
    logic [7:0] cmax;
    logic [7:0] cmin;

    function automatic logic [7:0] max_of(input int i, input logic [7:0] mon,
                                          input logic leap);
        case (i)
            0:       max_of = 8'h09;
            1, 2:    max_of = 8'h3B;
            3:       max_of = 8'h17;
            4:       max_of = days_in(mon, leap);
            5:       max_of = 8'h0C;
            default: max_of = 8'h63;
        endcase
    endfunction : max_of

    always_comb begin
        carry = tick & ~halt_s;
        cmax  = 8'h00;
        cmin  = 8'h00;
        for (int i = 0; i < N_CNT; i++) begin
            next_cnt[i] = cnt[i];
        end
        for (int i = 0; i <= C_YEAR; i++) begin
            cmax = max_of(i, cnt[C_MON], cnt[C_LEAP] == 8'h00);
            cmin = (i == C_DAY || i == C_MON) ? ONE_RESET : CNT_RESET;
            // leap steps with the year itself, not with the century wrap
            if (carry && i == C_YEAR) begin
                next_cnt[C_LEAP] = (cnt[C_LEAP] == {6'h00, LEAP_MAX}) ?
                    CNT_RESET : cnt[C_LEAP] + 8'h01;
            end
            if (carry) begin
                if (cnt[i] >= cmax) begin
                    next_cnt[i] = cmin;
                end else begin
                    next_cnt[i] = cnt[i] + 8'h01;
                    carry       = 1'b0;
                end
            end
        end
        // carry above uses the old value, so a write in a tick still ripples
        if (wr_pulse && wsel >= SEL_TENTHS && wsel <= SEL_LEAP) begin
            next_cnt[3'(wsel - SEL_TENTHS)] = (wsel == SEL_LEAP) ?
                {6'h00, wdata[1:0]} : wdata;
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            for (int i = 0; i < N_CNT; i++) begin
                cnt[i] <= (i == C_DAY || i == C_MON) ? ONE_RESET : CNT_RESET;
            end
        end else begin
            for (int i = 0; i < N_CNT; i++) begin
                cnt[i] <= next_cnt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interval timer
    logic [3:0] tctrl;
    logic       trun;
    logic       timeout;

    rtc_interval_timer u_timer (
        .clk       (SYS_CLK),
        .rst       (RESET),
        .tick      (tick),
        .ctrl_wr   (wr_pulse && wsel == SEL_TCTRL),
        .ctrl_data (wdata[3:0]),
        .run_wr    (wr_pulse && wsel == SEL_TRUN),
        .run_data  (wdata[0]),
        .ctrl      (tctrl),
        .running   (trun),
        .timeout   (timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // flags and read port; a set in the clearing cycle wins
    logic       stat_rd;
    logic       next_upd;
    logic       next_tflag;
    logic [7:0] next_rdata;

    assign stat_rd = rd_pulse && rsel == SEL_STATUS;

    always_comb begin
        next_upd   = (UPDATE_SEEN_FLAG & ~stat_rd) | (tick & ~halt_s);
        next_tflag = (TIMER_FLAG & ~stat_rd) | timeout;
        next_rdata = READ_DATA;
        if (rd_pulse) begin
            if (rsel == SEL_STATUS) begin
                next_rdata = 8'h00;
                next_rdata[ST_UPDATE] = UPDATE_SEEN_FLAG;
                next_rdata[ST_TIMER]  = TIMER_FLAG;
            end else if (rsel >= SEL_TENTHS && rsel <= SEL_LEAP) begin
                next_rdata = cnt[3'(rsel - SEL_TENTHS)];
            end else if (rsel == SEL_TCTRL) begin
                next_rdata = {4'h0, tctrl};
            end else if (rsel == SEL_TRUN) begin
                next_rdata = {7'h00, trun};
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            UPDATE_SEEN_FLAG <= 1'b0;
            TIMER_FLAG       <= 1'b0;
            READ_DATA        <= 8'h00;
            INT_N_OUT        <= 1'b0;
            INT_N_OE         <= 1'b1;
        end else begin
            UPDATE_SEEN_FLAG <= next_upd;
            TIMER_FLAG       <= next_tflag;
            READ_DATA        <= next_rdata;
            INT_N_OUT        <= 1'b0;
            INT_N_OE         <= ~next_tflag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    property p_update_sets;
        @(posedge SYS_CLK) disable iff (RESET)
        tick && !halt_s |=> UPDATE_SEEN_FLAG;
    endproperty
    a_update_sets: assert property (p_update_sets)
        else $error("update did not set the flag");

    property p_sec_carry;
        @(posedge SYS_CLK) disable iff (RESET)
        tick && !halt_s && !wr_pulse && cnt[0] == 8'h09 && cnt[1] < 8'h3B
        |=> cnt[0] == 8'h00 && cnt[1] == $past(cnt[1]) + 8'h01;
    endproperty
    a_sec_carry: assert property (p_sec_carry)
        else $error("tenths carry did not reach seconds");

    property p_only_on_tick;
        @(posedge SYS_CLK) disable iff (RESET)
        !tick && !wr_pulse |=> $stable(cnt[1]) && $stable(cnt[0]);
    endproperty
    a_only_on_tick: assert property (p_only_on_tick)
        else $error("counter moved without an update");

    property p_write_no_carry;
        @(posedge SYS_CLK) disable iff (RESET)
        wr_pulse && !tick && wsel == SEL_SEC |=> $stable(cnt[2]);
    endproperty
    a_write_no_carry: assert property (p_write_no_carry)
        else $error("write outside update disturbed neighbour");

    property p_read_clears;
        @(posedge SYS_CLK) disable iff (RESET)
        stat_rd && !tick |=> !UPDATE_SEEN_FLAG;
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear flag");

    property p_timeout_pin;
        @(posedge SYS_CLK) disable iff (RESET)
        timeout |=> TIMER_FLAG && !INT_N_OE && !INT_N_OUT;
    endproperty
    a_timeout_pin: assert property (p_timeout_pin)
        else $error("timeout did not raise flag and pin");

    property p_leap_range;
        @(posedge SYS_CLK) disable iff (RESET)
        cnt[C_LEAP] <= {6'h00, LEAP_MAX};
    endproperty
    a_leap_range: assert property (p_leap_range)
        else $error("leap counter out of range");

    property p_halt_holds;
        @(posedge SYS_CLK) disable iff (RESET)
        halt_s && !wr_pulse |=> $stable(cnt[0]);
    endproperty
    a_halt_holds: assert property (p_halt_holds)
        else $error("counters moved during halt");

    c_write:   cover property (@(posedge SYS_CLK) disable iff (RESET)
        wr_pulse && tick);
    c_rd_flag: cover property (@(posedge SYS_CLK) disable iff (RESET)
        stat_rd && UPDATE_SEEN_FLAG);
    c_timeout: cover property (@(posedge SYS_CLK) disable iff (RESET)
        timeout);
endmodule : rtc_core

// ### sim/rtc_host_model.sv
`timescale 1ns/100ps
// host side: strobes rise just after an edge, hold 5 edges, then release
module rtc_host_model (
    input  wire logic       clk,
    input  wire logic       pfail_req,
    input  wire logic [7:0] read_data,
    output logic            early_warn,
    output logic            wr_stb,
    output logic      [3:0] wr_sel,
    output logic      [7:0] wr_data,
    output logic            rd_stb,
    output logic      [3:0] rd_sel
);
    logic raw_wr  = 1'b0;
    logic lockout = 1'b0;

    initial begin
        early_warn = 1'b0;
        rd_stb     = 1'b0;
        wr_sel     = 4'h0;
        wr_data    = 8'h00;
        rd_sel     = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // warning comes a cycle ahead of lockout, lockout held to settle
    always @(posedge clk) begin
        early_warn <= pfail_req;
        if (!raw_wr)
            lockout <= early_warn;
    end
    // lockout only moves while idle, so a write is never cut short
    assign wr_stb = raw_wr & ~lockout;

    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] sel, input logic [7:0] data);
        @(posedge clk);
        #1;
        wr_sel  = sel;
        wr_data = data;
        raw_wr  = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        raw_wr  = 1'b0;
        wr_data = ~data;
        repeat (3) @(posedge clk);
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] sel, output logic [7:0] data);
        @(posedge clk);
        #1;
        rd_sel = sel;
        rd_stb = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        data   = read_data;
        rd_stb = 1'b0;
        rd_sel = ~sel;
        repeat (3) @(posedge clk);
        #1;
    endtask : rd
endmodule : rtc_host_model

// ### sim/rtc_core_tb.sv
`timescale 1ns/100ps
module rtc_core_tb;
    import rtc_pkg::*;
    localparam int TK = 20;

    logic       SYS_CLK;
    logic       RESET;
    logic       HALT_COUNT;
    logic       pfail_req;
    logic       WR_STB;
    logic [3:0] WR_SEL;
    logic [7:0] WR_DATA;
    logic       RD_STB;
    logic [3:0] RD_SEL;
    logic [7:0] READ_DATA;
    logic       UPDATE_SEEN_FLAG;
    logic       TIMER_FLAG;
    logic       INT_N_OUT;
    logic       INT_N_OE;
    wire        int_n = INT_N_OE ? 1'b1 : INT_N_OUT;
    int         errors;
    int         check_count;
    int         cyc;

    rtc_core #(.TICK_CYCLES(TK)) rtc_core_i (.SYS_CLK(SYS_CLK),
        .RESET(RESET), .WR_STB(WR_STB), .WR_SEL(WR_SEL), .WR_DATA(WR_DATA),
        .RD_STB(RD_STB), .RD_SEL(RD_SEL), .HALT_COUNT(HALT_COUNT),
        .READ_DATA(READ_DATA), .UPDATE_SEEN_FLAG(UPDATE_SEEN_FLAG),
        .TIMER_FLAG(TIMER_FLAG), .INT_N_OUT(INT_N_OUT),
        .INT_N_OE(INT_N_OE));
    rtc_host_model rtc_host_model_i (.clk(SYS_CLK), .pfail_req(pfail_req),
        .read_data(READ_DATA), .early_warn(), .wr_stb(WR_STB),
        .wr_sel(WR_SEL), .wr_data(WR_DATA), .rd_stb(RD_STB),
        .rd_sel(RD_SEL));

    initial begin
        SYS_CLK = 1'b0;
        forever #25 SYS_CLK = ~SYS_CLK;
    end
    always @(posedge SYS_CLK) cyc <= cyc + 1;

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rdchk(input string what, input logic [3:0] sel,
                         input logic [7:0] exp);
        logic [7:0] v;
        rtc_host_model_i.rd(sel, v);
        check(what, v, exp);
    endtask : rdchk

    // bounded wait on one of the two flags; overrun ends the run
    task automatic wait_flag(input bit tmr, input int limit);
        int n;
        n = 0;
        while ((tmr ? TIMER_FLAG : UPDATE_SEEN_FLAG) !== 1'b1) begin
            if (n >= limit) begin
                errors++;
                $display("mismatch flag_wait exp 1 seen 0");
                tally_and_finish();
            end
            @(posedge SYS_CLK);
            #1;
            n++;
        end
    endtask : wait_flag

    // counters 1..8 after a full wrap equal their reset values
    task automatic chain_check();
        logic [7:0] exp [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                                8'h01, 8'h01, 8'h00, 8'h00};
        for (int i = 0; i < 8; i++)
            rdchk("counter", 4'(i + 1), exp[i]);
    endtask : chain_check

    task automatic halt_load(input logic [3:0] sel[], input logic [7:0] d[]);
        logic [7:0] v;
        HALT_COUNT = 1'b1;
        // drop any flag left from the last update before judging the halt
        rtc_host_model_i.rd(SEL_STATUS, v);
        check("tmr_idle", {7'h00, v[ST_TIMER]}, 8'h00);
        foreach (sel[i])
            rtc_host_model_i.wr(sel[i], d[i]);
        rdchk("status_clear", SEL_STATUS, 8'h00);
        HALT_COUNT = 1'b0;
        wait_flag(1'b0, 3 * TK);
        HALT_COUNT = 1'b1;
    endtask : halt_load

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        check("read_data", READ_DATA, 8'h00);
        check("int_pin", {7'h00, int_n}, 8'h01);
        chain_check();
        rdchk("unmapped", 4'hB, 8'h00);
        $display("test reset done");
    endtask : t_reset

    task automatic t_carry();
        halt_load('{SEL_TENTHS, SEL_SEC, SEL_MIN, SEL_HOUR, SEL_DAY,
                    SEL_MONTH, SEL_YEAR, SEL_LEAP},
                  '{8'h09, 8'h3B, 8'h3B, 8'h17, 8'h1F, 8'h0C, 8'h63, 8'h03});
        chain_check();
        halt_load('{SEL_TENTHS, SEL_SEC, SEL_MIN, SEL_HOUR, SEL_DAY,
                    SEL_MONTH, SEL_YEAR, SEL_LEAP},
                  '{8'h09, 8'h3B, 8'h3B, 8'h17, 8'h1F, 8'h0C, 8'h05, 8'h01});
        rdchk("year", SEL_YEAR, 8'h06);
        rdchk("leap", SEL_LEAP, 8'h02);
        $display("test carry done");
    endtask : t_carry

    task automatic t_quiet_write();
        halt_load('{SEL_SEC, SEL_MIN}, '{8'h0A, 8'h07});
        @(posedge SYS_CLK);
        #1;
        HALT_COUNT = 1'b0;
        rdchk("status_prev", SEL_STATUS, 8'h01);
        wait_flag(1'b0, 3 * TK);
        rtc_host_model_i.wr(SEL_MIN, 8'h14);
        HALT_COUNT = 1'b1;
        rdchk("tenths", SEL_TENTHS, 8'h02);
        rdchk("seconds", SEL_SEC, 8'h0A);
        rdchk("minutes", SEL_MIN, 8'h14);
        $display("test quiet_write done");
    endtask : t_quiet_write

    task automatic t_lockout();
        pfail_req = 1'b1;
        repeat (3) @(posedge SYS_CLK);
        rtc_host_model_i.wr(SEL_MIN, 8'h2A);
        rdchk("locked_min", SEL_MIN, 8'h14);
        pfail_req = 1'b0;
        repeat (3) @(posedge SYS_CLK);
        rtc_host_model_i.wr(SEL_MIN, 8'h2A);
        rdchk("open_min", SEL_MIN, 8'h2A);
        $display("test lockout done");
    endtask : t_lockout

    task automatic t_flag_read();
        HALT_COUNT = 1'b0;
        rdchk("status_prev", SEL_STATUS, 8'h01);
        wait_flag(1'b0, 3 * TK);
        rdchk("status", SEL_STATUS, 8'h01);
        check("flag_cleared", {7'h00, UPDATE_SEEN_FLAG}, 8'h00);
        $display("test flag_read done");
    endtask : t_flag_read

    // clear, re-read if an update slipped in, then catch a fresh update
    task automatic sync_update(output logic [7:0] first);
        logic [7:0] v;
        rtc_host_model_i.rd(SEL_STATUS, first);
        for (int k = 0; k < 2 && UPDATE_SEEN_FLAG === 1'b1; k++)
            rtc_host_model_i.rd(SEL_STATUS, v);
        wait_flag(1'b0, 3 * TK);
    endtask : sync_update

    // each period code, single shot, started in step with an update
    task automatic t_periods();
        int ticks [8] = '{0, 1, 5, 10, 50, 100, 300, 600};
        int t0;
        int d;
        logic [7:0] v;
        for (int c = 1; c < 8; c++) begin
            rtc_host_model_i.wr(SEL_TCTRL, 8'(c));
            sync_update(v);
            check("tmr_clear", v & 8'h02, 8'h00);
            t0 = cyc;
            rtc_host_model_i.wr(SEL_TRUN, 8'h01);
            wait_flag(1'b1, TK * ticks[c] + 10);
            d = cyc - t0;
            check("period_ok", 8'((d >= TK * ticks[c] - 2) &&
                  (d <= TK * ticks[c] + 4)), 8'h01);
            check("int_pin", {7'h00, int_n}, 8'h00);
            rdchk("status_tmr", SEL_STATUS, 8'h03);
            check("int_free", {7'h00, int_n}, 8'h01);
            if (c == 1) begin
                repeat (3 * TK) @(posedge SYS_CLK);
                #1;
                check("single_shot", {7'h00, TIMER_FLAG}, 8'h00);
            end
        end
        $display("test periods done");
    endtask : t_periods

    task automatic t_watchdog();
        HALT_COUNT = 1'b1;
        rtc_host_model_i.wr(SEL_TCTRL, 8'h0A);
        rtc_host_model_i.wr(SEL_TRUN, 8'h01);
        repeat (100) @(posedge SYS_CLK);
        #1;
        check("halted_tmr", {7'h00, TIMER_FLAG}, 8'h00);
        HALT_COUNT = 1'b0;
        for (int i = 0; i < 5; i++) begin
            rtc_host_model_i.wr(SEL_TRUN, 8'h00);
            rtc_host_model_i.wr(SEL_TRUN, 8'h01);
            repeat (50) @(posedge SYS_CLK);
            #1;
            check("kicked", {7'h00, TIMER_FLAG}, 8'h00);
        end
        wait_flag(1'b1, 5 * TK + 10);
        rdchk("status_tmr", SEL_STATUS, 8'h03);
        wait_flag(1'b1, 5 * TK + 10);
        rtc_host_model_i.wr(SEL_TCTRL, 8'h00);
        rdchk("status_both", SEL_STATUS, 8'h03);
        repeat (8 * TK) @(posedge SYS_CLK);
        #1;
        check("disabled", {7'h00, TIMER_FLAG}, 8'h00);
        $display("test watchdog done");
    endtask : t_watchdog

    ////////////////////////////////////////////////////////////////////////
    initial begin
        errors      = 0;
        check_count = 0;
        cyc         = 0;
        RESET       = 1'b1;
        HALT_COUNT  = 1'b1;
        pfail_req   = 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1;
        RESET = 1'b0;
        t_reset();
        t_carry();
        t_quiet_write();
        t_lockout();
        t_flag_read();
        t_periods();
        t_watchdog();
        tally_and_finish();
    end
endmodule : rtc_core_tb
